// file: pkg/dsp_consts.vh
// Constants shared by the dual serial port unit
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// Internal mode codes
`define DSP_MODE_SYNC 2'h0
`define DSP_MODE_UART8 2'h1
`define DSP_MODE_UART9 2'h2
`define DSP_MODE_UART9F 2'h3

// Baud generator reload values: tick period is value plus one clock
`define DSP_SYNC_DIV 16'h0005
`define DSP_FIXED_DIV 16'h000B

// Oversampling at 16 ticks per UART bit: last tick index and mid-bit index
`define DSP_SUB_LAST 4'hF
`define DSP_SUB_MID 4'h7

// Transmit frame lengths in bits, then receive data bit counts
`define DSP_BITS_SYNC 4'h8
`define DSP_BITS_U8 4'hA
`define DSP_BITS_U9 4'hB
`define DSP_RXBITS_U8 4'h8
`define DSP_RXBITS_U9 4'h9

// One-hot states
`define DSP_TX_IDLE 2'h1
`define DSP_TX_BUSY 2'h2
`define DSP_RX_IDLE 4'h1
`define DSP_RX_START 4'h2
`define DSP_RX_DATA 4'h4
`define DSP_RX_STOP 4'h8

`endif

// file: design/dsp_baud.v
// Programmable baud tick generator
`timescale 1ns/1ps
`include "dsp_consts.vh"

module dsp_baud (
  input wire sys_clk,
  input wire reset,
  input wire [15:0] div,
  output wire tick
);
  reg [15:0] cnt_ff;

  // Pulse once every div+1 clocks
  assign tick = (cnt_ff >= div);

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 16'h0000;
    end else if (tick) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule

// file: design/dsp_serial_ports.v
// Two independent serial ports: port 0 sync or UART, port 1 UART only
`timescale 1ns/1ps
`include "dsp_consts.vh"

// What this block does
// - Two ports run fully independently, simultaneously
// - Mode and speed set separately per port
// - Port 0 sync and async; port 1 async
// - Sync mode: device drives clock, half-duplex
// - Async mode: transmitter and receiver run concurrently
// - Completed word moves into receive holding register
// - Port 0: sync fixed, UART8 variable, UART9 either
// - Port 1: UART8 and UART9, variable rate
// - Each port has its own baud generator
module dsp_serial_ports (
  input wire sys_clk,
  input wire reset,
  input wire [1:0] p0_mode,
  input wire [15:0] p0_baud_div,
  input wire p0_rx_en,
  input wire [8:0] p0_tx_data,
  input wire p0_tx_valid,
  output wire p0_tx_ready,
  output wire [8:0] p0_rx_data,
  output wire p0_rx_valid,
  input wire p0_rx_ack,
  output wire p0_overrun,
  input wire p0_rxd_i,
  output wire p0_rxd_o,
  output wire p0_rxd_oe,
  output wire p0_txd_o,
  input wire p1_mode,
  input wire [15:0] p1_baud_div,
  input wire p1_rx_en,
  input wire [8:0] p1_tx_data,
  input wire p1_tx_valid,
  output wire p1_tx_ready,
  output wire [8:0] p1_rx_data,
  output wire p1_rx_valid,
  input wire p1_rx_ack,
  output wire p1_overrun,
  input wire p1_rxd_i,
  output wire p1_txd_o
);
  wire [1:0] mode_w [0:1];
  wire [15:0] div_w [0:1];
  wire [8:0] txd_w [0:1];
  wire [1:0] rx_en_w;
  wire [1:0] tx_valid_w;
  wire [1:0] rx_ack_w;
  wire [1:0] rxd_w;
  wire [1:0] tx_ready_w;
  wire [8:0] rx_data_w [0:1];
  wire [1:0] rx_valid_w;
  wire [1:0] overrun_w;
  wire [1:0] line_o_w;
  wire [1:0] data_o_w;
  wire [1:0] data_oe_w;

  // Port 1 has only the two UART codes
  assign mode_w[0] = p0_mode;
  assign mode_w[1] = p1_mode ? `DSP_MODE_UART9 : `DSP_MODE_UART8;
  assign div_w[0] = p0_baud_div;
  assign div_w[1] = p1_baud_div;
  assign txd_w[0] = p0_tx_data;
  assign txd_w[1] = p1_tx_data;
  assign rx_en_w = {p1_rx_en, p0_rx_en};
  assign tx_valid_w = {p1_tx_valid, p0_tx_valid};
  assign rx_ack_w = {p1_rx_ack, p0_rx_ack};
  assign rxd_w = {p1_rxd_i, p0_rxd_i};

  assign p0_tx_ready = tx_ready_w[0];
  assign p0_rx_data = rx_data_w[0];
  assign p0_rx_valid = rx_valid_w[0];
  assign p0_overrun = overrun_w[0];
  assign p0_rxd_o = data_o_w[0];
  assign p0_rxd_oe = data_oe_w[0];
  assign p0_txd_o = line_o_w[0];
  assign p1_tx_ready = tx_ready_w[1];
  assign p1_rx_data = rx_data_w[1];
  assign p1_rx_valid = rx_valid_w[1];
  assign p1_overrun = overrun_w[1];
  assign p1_txd_o = line_o_w[1];

  // Frame length in bits for the transmit shifter
  function [3:0] dsp_tx_bits;
    input sync;
    input nine;
    begin
      if (sync) begin
        dsp_tx_bits = `DSP_BITS_SYNC;
      end else if (nine) begin
        dsp_tx_bits = `DSP_BITS_U9;
      end else begin
        dsp_tx_bits = `DSP_BITS_U8;
      end
    end
  endfunction

  genvar g;
  generate
    // Each port is a separate copy with no shared state
    for (g = 0; g < 2; g = g + 1) begin : gen_port
      reg [1:0] tx_st_ff;
      reg [10:0] tx_sh_ff;
      reg [3:0] tx_bit_ff;
      reg [3:0] tx_sub_ff;
      reg [3:0] rx_st_ff;
      reg [8:0] rx_sh_ff;
      reg [3:0] rx_bit_ff;
      reg [3:0] rx_sub_ff;
      reg sclk_ff;
      reg [8:0] hold_ff;
      reg hold_vld_ff;
      reg ovr_ff;
      wire tick;
      wire is_sync;
      wire nine;
      wire [15:0] div_sel;
      wire tx_go;
      wire rx_sync_go;
      wire rx_done;

      // Sync mode exists only on port 0
      assign is_sync = (g == 0) && (mode_w[g] == `DSP_MODE_SYNC);
      assign nine = (mode_w[g] == `DSP_MODE_UART9) || (mode_w[g] == `DSP_MODE_UART9F);
      // Fixed rate for sync and fixed UART9, variable otherwise
      assign div_sel = is_sync ? `DSP_SYNC_DIV :
                       (mode_w[g] == `DSP_MODE_UART9F) ? `DSP_FIXED_DIV : div_w[g];

      dsp_baud u_baud (
        .sys_clk(sys_clk),
        .reset(reset),
        .div(div_sel),
        .tick(tick)
      );

      // Sync mode moves one direction at a time
      assign tx_ready_w[g] = (tx_st_ff == `DSP_TX_IDLE) &&
                             !(is_sync && (rx_st_ff != `DSP_RX_IDLE));
      assign tx_go = tx_ready_w[g] && tx_valid_w[g];
      assign rx_sync_go = is_sync && rx_en_w[g] && (rx_st_ff == `DSP_RX_IDLE) &&
                          (tx_st_ff == `DSP_TX_IDLE) && !tx_valid_w[g];
      assign rx_done = tick && (rx_st_ff == `DSP_RX_STOP) &&
                       (is_sync || ((rx_sub_ff == `DSP_SUB_LAST) && rxd_w[g]));

      // Sync: shift clock on the txd pin, data on the two-way pin
      assign line_o_w[g] = is_sync ? sclk_ff : tx_sh_ff[0];
      assign data_o_w[g] = tx_sh_ff[0];
      assign data_oe_w[g] = is_sync && (tx_st_ff == `DSP_TX_BUSY);
      assign rx_data_w[g] = hold_ff;
      assign rx_valid_w[g] = hold_vld_ff;
      assign overrun_w[g] = ovr_ff;

      always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          tx_st_ff <= `DSP_TX_IDLE;
          tx_sh_ff <= 11'h7FF;
          tx_bit_ff <= 4'h0;
          tx_sub_ff <= 4'h0;
          rx_st_ff <= `DSP_RX_IDLE;
          rx_sh_ff <= 9'h000;
          rx_bit_ff <= 4'h0;
          rx_sub_ff <= 4'h0;
          sclk_ff <= 1'b1;
        end else begin
          // Transmitter
          case (tx_st_ff)
            `DSP_TX_IDLE: begin
              if (tx_go) begin
                // Data LSB first; UART frames add a low start bit and a high stop bit, sync sends data only
                if (is_sync) begin
                  tx_sh_ff <= {3'h7, txd_w[g][7:0]};
                end else if (nine) begin
                  tx_sh_ff <= {1'b1, txd_w[g], 1'b0};
                end else begin
                  tx_sh_ff <= {2'h3, txd_w[g][7:0], 1'b0};
                end
                tx_bit_ff <= dsp_tx_bits(is_sync, nine);
                tx_sub_ff <= 4'h0;
                tx_st_ff <= `DSP_TX_BUSY;
              end
            end
            `DSP_TX_BUSY: begin
              if (tick && is_sync) begin
                // Data moves on the falling shift clock and stands across the rising one;
                // one extra tick after the last rising edge keeps the data pin driven
                if (tx_bit_ff == 4'h0) begin
                  tx_st_ff <= `DSP_TX_IDLE;
                end else begin
                  sclk_ff <= ~sclk_ff;
                  if (!sclk_ff) begin
                    tx_bit_ff <= tx_bit_ff - 4'h1;
                  end else if (tx_bit_ff != `DSP_BITS_SYNC) begin
                    tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                  end
                end
              end else if (tick) begin
                tx_sub_ff <= tx_sub_ff + 4'h1;
                if (tx_sub_ff == `DSP_SUB_LAST) begin
                  tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                  tx_bit_ff <= tx_bit_ff - 4'h1;
                  if (tx_bit_ff == 4'h1) begin
                    tx_st_ff <= `DSP_TX_IDLE;
                  end
                end
              end
            end
            default: begin
              tx_st_ff <= `DSP_TX_IDLE;
            end
          endcase

          // Receiver runs alongside the transmitter in UART modes
          case (rx_st_ff)
            `DSP_RX_IDLE: begin
              rx_sub_ff <= 4'h0;
              if (rx_sync_go) begin
                rx_bit_ff <= `DSP_BITS_SYNC;
                rx_st_ff <= `DSP_RX_DATA;
              end else if (!is_sync && rx_en_w[g] && !rxd_w[g]) begin
                rx_st_ff <= `DSP_RX_START;
              end
            end
            `DSP_RX_START: begin
              if (tick) begin
                rx_sub_ff <= rx_sub_ff + 4'h1;
                if (rx_sub_ff == `DSP_SUB_MID) begin
                  // Glitch check at mid start bit
                  rx_sub_ff <= 4'h0;
                  rx_bit_ff <= nine ? `DSP_RXBITS_U9 : `DSP_RXBITS_U8;
                  rx_st_ff <= rxd_w[g] ? `DSP_RX_IDLE : `DSP_RX_DATA;
                end
              end
            end
            `DSP_RX_DATA: begin
              if (tick && is_sync) begin
                sclk_ff <= ~sclk_ff;
                // Sample on the rising shift clock edge
                if (!sclk_ff) begin
                  rx_sh_ff <= {rxd_w[g], rx_sh_ff[8:1]};
                  rx_bit_ff <= rx_bit_ff - 4'h1;
                  if (rx_bit_ff == 4'h1) begin
                    rx_st_ff <= `DSP_RX_STOP;
                  end
                end
              end else if (tick) begin
                rx_sub_ff <= rx_sub_ff + 4'h1;
                if (rx_sub_ff == `DSP_SUB_LAST) begin
                  rx_sh_ff <= {rxd_w[g], rx_sh_ff[8:1]};
                  rx_bit_ff <= rx_bit_ff - 4'h1;
                  if (rx_bit_ff == 4'h1) begin
                    rx_st_ff <= `DSP_RX_STOP;
                  end
                end
              end
            end
            `DSP_RX_STOP: begin
              if (tick) begin
                rx_sub_ff <= rx_sub_ff + 4'h1;
                // Bad stop bit drops the frame
                if (is_sync || (rx_sub_ff == `DSP_SUB_LAST)) begin
                  rx_st_ff <= `DSP_RX_IDLE;
                end
              end
            end
            default: begin
              rx_st_ff <= `DSP_RX_IDLE;
            end
          endcase
        end
      end

      // Holding register frees the shifter for the next word
      always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          hold_ff <= 9'h000;
          hold_vld_ff <= 1'b0;
          ovr_ff <= 1'b0;
        end else begin
          ovr_ff <= rx_done && hold_vld_ff && !rx_ack_w[g];
          if (rx_done) begin
            hold_ff <= nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
            hold_vld_ff <= 1'b1;
          end else if (rx_ack_w[g]) begin
            hold_vld_ff <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

// file: tb/dsp_serial_ports_sva.sv
// Port assertions for the dual serial port unit
`timescale 1ns/1ps
module dsp_serial_ports_sva (
  input wire sys_clk,
  input wire reset,
  input wire [1:0] p0_mode,
  input wire p0_tx_valid,
  input wire p0_tx_ready,
  input wire p0_txd_o,
  input wire p0_rxd_oe,
  input wire p0_rx_valid,
  input wire p0_rx_ack,
  input wire [8:0] p0_rx_data,
  input wire p1_tx_valid,
  input wire p1_tx_ready,
  input wire p1_txd_o,
  input wire p1_rx_valid,
  input wire p1_rx_ack,
  input wire [8:0] p1_rx_data,
  input wire p1_overrun
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  p0_start_a: assert property (p0_tx_valid && p0_tx_ready && p0_mode != 2'h0
    |=> !p0_txd_o && !p0_tx_ready) else $error("p0 start bit missing");
  p1_start_a: assert property (p1_tx_valid && p1_tx_ready
    |=> !p1_txd_o && !p1_tx_ready) else $error("p1 start bit missing");
  frame_busy_a: assert property ($fell(p1_tx_ready) |-> !p1_tx_ready [*8])
    else $error("p1 frame ended early");
  rx_hold_a: assert property (p0_rx_valid && !p0_rx_ack
    |=> p0_rx_valid && $stable(p0_rx_data)) else $error("p0 held word lost");
  ack_clear_a: assert property (p1_rx_valid && p1_rx_ack
    |=> !p1_rx_valid || p1_overrun || $changed(p1_rx_data)) else $error("ack ignored");
  sync_only_a: assert property (p0_rxd_oe |-> p0_mode == 2'h0 && !p0_tx_ready)
    else $error("data driven outside sync transfer");
  line_idle_a: assert property ((!p0_tx_ready || p0_txd_o) && (!p1_tx_ready || p1_txd_o))
    else $error("line not idle high");
  sclk_low_a: assert property ($fell(p0_txd_o) && p0_mode == 2'h0
    |-> !p0_txd_o [*6] ##1 p0_txd_o) else $error("shift clock low phase wrong");
  ovr_full_a: assert property (p1_overrun |-> p1_rx_valid)
    else $error("overrun without held word");
  cover property (p1_overrun);
  cover property (p0_rxd_oe);
  cover property ($rose(p0_rx_valid) && p0_mode == 2'h0);
endmodule
bind dsp_serial_ports dsp_serial_ports_sva dsp_serial_ports_sva_inst (.*);

// file: tb/dsp_remote.sv
// Remote serial device model: UART and sync partner
`timescale 1ns/1ps
module dsp_remote (
  input wire sys_clk,
  input wire txd,
  input wire dat_i,
  input wire sync_mode,
  input wire [15:0] bit_clks,
  input wire [3:0] nbits,
  output reg line_o
);
  reg [8:0] got = 9'h000;
  reg stop_ok = 1'b0;
  reg [7:0] sq = 8'h00;
  integer i;
  initial line_o = 1'b1;
  // Start bit may be one tick short, so aim a little before the centre
  always @(negedge txd) begin
    if (!sync_mode) begin
      got = 9'h000;
      repeat (bit_clks + bit_clks / 2 - bit_clks / 16) @(posedge sys_clk);
      for (i = 0; i < nbits; i = i + 1) begin
        got[i] = txd;
        repeat (bit_clks) @(posedge sys_clk);
      end
      stop_ok = txd;
    end else begin
      line_o <= sq[0];
      sq = {1'b1, sq[7:1]};
    end
  end
  always @(posedge txd) if (sync_mode) got = {1'b0, dat_i, got[7:1]};
  task send(input [8:0] w, input [3:0] n);
    integer k;
    begin
      for (k = 0; k < n + 2; k = k + 1) begin
        @(posedge sys_clk) line_o <= (k == 0) ? 1'b0 : (k > n) ? 1'b1 : w[k-1];
        repeat (bit_clks - 1) @(posedge sys_clk);
      end
    end
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the dual serial port unit
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [1:0] p0_mode = 2'h1;
  reg p1_mode = 1'b0;
  reg [15:0] p0_baud_div = 16'h0001;
  reg [15:0] p1_baud_div = 16'h0002;
  reg p0_rx_en = 1'b1;
  reg p1_rx_en = 1'b1;
  reg [8:0] p0_tx_data = 9'h000;
  reg [8:0] p1_tx_data = 9'h000;
  reg p0_tx_valid = 1'b0;
  reg p1_tx_valid = 1'b0;
  reg p0_rx_ack = 1'b0;
  reg p1_rx_ack = 1'b0;
  reg [8:0] ovr_cnt = 9'h000;
  integer error_cnt = 0;
  integer samples_checked = 0;
  wire [8:0] p0_rx_data, p1_rx_data;
  wire p0_tx_ready, p0_rx_valid, p0_overrun, p0_rxd_o, p0_rxd_oe, p0_txd_o, r0_line;
  wire p1_tx_ready, p1_rx_valid, p1_overrun, p1_txd_o, p1_rxd_i;
  wire p0_rxd_i = p0_rxd_oe ? p0_rxd_o : r0_line;
  always #20 sys_clk = ~sys_clk;
  dsp_serial_ports dsp_serial_ports_inst (.*);
  dsp_remote rem0 (.sys_clk(sys_clk), .txd(p0_txd_o), .dat_i(p0_rxd_i),
    .sync_mode(p0_mode == 2'h0), .nbits((p0_mode == 2'h1) ? 4'h8 : 4'h9), .line_o(r0_line),
    .bit_clks((p0_mode == 2'h3) ? 16'h00C0 : {p0_baud_div[11:0] + 12'h001, 4'h0}));
  dsp_remote rem1 (.sys_clk(sys_clk), .txd(p1_txd_o), .dat_i(p1_rxd_i), .sync_mode(1'b0),
    .nbits(p1_mode ? 4'h9 : 4'h8), .line_o(p1_rxd_i),
    .bit_clks({p1_baud_div[11:0] + 12'h001, 4'h0}));
  always @(posedge sys_clk) if (p1_overrun === 1'b1) ovr_cnt <= ovr_cnt + 9'h001;
  function [8:0] msk(input [8:0] w, input nine);
    msk = nine ? w : {1'b0, w[7:0]};
  endfunction
  task chk(input [8:0] got, input [8:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
    end
  endtask
  task ack_both;
    begin
      @(posedge sys_clk) p0_rx_ack <= 1'b1;
      p1_rx_ack <= 1'b1;
      @(posedge sys_clk) p0_rx_ack <= 1'b0;
      p1_rx_ack <= 1'b0;
      @(negedge sys_clk);
      chk({7'h00, p0_rx_valid, p1_rx_valid}, 9'h000);
      chk({7'h00, p0_overrun, p1_overrun}, 9'h000);
    end
  endtask
  // Both ports send and receive at once, each at its own rate
  task t_uart(input [1:0] m0, input m1, input [8:0] w0, input [8:0] w1);
    integer n;
    begin
      @(posedge sys_clk) p0_mode <= m0;
      p1_mode <= m1;
      p0_tx_data <= w0;
      p1_tx_data <= w1;
      p0_tx_valid <= 1'b1;
      p1_tx_valid <= 1'b1;
      @(posedge sys_clk) p0_tx_valid <= 1'b0;
      p1_tx_valid <= 1'b0;
      fork
        rem0.send(w1, (m0 == 2'h1) ? 4'h8 : 4'h9);
        rem1.send(w0, m1 ? 4'h9 : 4'h8);
      join
      @(negedge sys_clk);
      chk({7'h00, p0_rx_valid, p1_rx_valid}, 9'h003);
      chk(p0_rx_data, msk(w1, m0 != 2'h1));
      chk(p1_rx_data, msk(w0, m1));
      for (n = 0; n < 3000 && (p0_tx_ready & p1_tx_ready) !== 1'b1; n = n + 1) @(negedge sys_clk);
      chk(rem0.got, msk(w0, m0 != 2'h1));
      chk(rem1.got, msk(w1, m1));
      chk({7'h00, rem0.stop_ok, rem1.stop_ok}, 9'h003);
      ack_both;
      $display("uart test done, modes %0d %0d", m0, m1);
    end
  endtask
  // Second word arrives before the first is read
  task t_ovr;
    begin
      rem1.send(9'h033, 4'h8);
      rem1.send(9'h0CC, 4'h8);
      @(negedge sys_clk);
      chk({8'h00, p1_rx_valid}, 9'h001);
      chk(p1_rx_data, 9'h0CC);
      chk(ovr_cnt, 9'h001);
      ack_both;
      $display("overrun test done");
    end
  endtask
  // Port 0 shifts a byte out, then one in, on its own clock
  task t_sync;
    integer n;
    begin
      @(posedge sys_clk) p0_rx_en <= 1'b0;
      p0_mode <= 2'h0;
      p0_tx_data <= 9'h0B4;
      p0_tx_valid <= 1'b1;
      @(posedge sys_clk) p0_tx_valid <= 1'b0;
      @(negedge sys_clk);
      for (n = 0; n < 400 && p0_tx_ready !== 1'b1; n = n + 1) @(negedge sys_clk);
      chk(rem0.got, 9'h0B4);
      rem0.sq = 8'h6D;
      @(posedge sys_clk) p0_rx_en <= 1'b1;
      for (n = 0; n < 400 && p0_rx_valid !== 1'b1; n = n + 1) @(negedge sys_clk);
      @(posedge sys_clk) p0_rx_en <= 1'b0;
      chk(p0_rx_data, 9'h06D);
      $display("sync test done");
    end
  endtask
  task print_verdict;
    begin
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_uart(2'h1, 1'b0, 9'h0A5, 9'h03C);
    t_uart(2'h2, 1'b1, 9'h1C3, 9'h15A);
    t_uart(2'h3, 1'b0, 9'h0FF, 9'h100);
    t_ovr;
    t_sync;
    print_verdict;
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt = error_cnt + 1;
    print_verdict;
  end
endmodule
